// *** pkg/fcode_if.sv ***
// Port group between the control logic and the function code table
`timescale 1ns/1ps
interface fcode_if;
  import remote_io_pkg::*;
  logic wr_en;
  logic [TBL_W-1:0] wr_idx;
  logic [CODE_W-1:0] wr_data;
  logic [TBL_W-1:0] rd_idx;
  logic [CODE_W-1:0] rd_data;
  logic [SLOTS-1:0][CODE_W-1:0] in_codes;
  logic [SLOTS-1:0][CODE_W-1:0] out_codes;
  modport table_side (input wr_en, wr_idx, wr_data, rd_idx,
                      output rd_data, in_codes, out_codes);
  modport ctrl_side (output wr_en, wr_idx, wr_data, rd_idx,
                     input rd_data, in_codes, out_codes);
endinterface : fcode_if

// *** pkg/remote_io_pkg.sv ***
// Constants for remote I/O mapping and operation stop control
package remote_io_pkg;
  localparam int SLOTS = 16;
  localparam int CODE_W = 8;
  localparam int ADDR_W = 8;
  localparam int POS_W = 32;
  localparam int TBL_W = 5;
  // Register byte addresses
  localparam logic [ADDR_W-1:0] IN_CODE_BASE = 8'h00;
  localparam logic [ADDR_W-1:0] OUT_CODE_BASE = 8'h40;
  localparam logic [ADDR_W-1:0] STOP_METHOD_ADDR = 8'h80;
  localparam logic [ADDR_W-1:0] STATUS_ADDR = 8'h84;
  localparam logic [ADDR_W-1:0] TBL_SPAN = 8'h80;
  // Stop method encodings
  localparam logic [1:0] STOP_IMMEDIATE = 2'h0;
  localparam logic [1:0] STOP_DECEL = 2'h3;
  // Input function codes
  localparam logic [CODE_W-1:0] FN_NONE = 8'h00;
  localparam logic [CODE_W-1:0] FN_DEEXCITE = 8'h01;
  localparam logic [CODE_W-1:0] FN_DEVIATION_FLUSH = 8'h08;
  localparam logic [CODE_W-1:0] FN_STOP = 8'h09;
  localparam logic [CODE_W-1:0] FN_OPERATOR_PANEL_PERMIT = 8'h0a;
  // Output function codes
  localparam logic [CODE_W-1:0] FN_FORWARD_LIMIT_ECHO = 8'h1c;
  localparam logic [CODE_W-1:0] FN_REVERSE_LIMIT_ECHO = 8'h1d;
  localparam logic [CODE_W-1:0] FN_FAULT_NO = 8'h81;
  localparam logic [CODE_W-1:0] FN_READY = 8'h85;
  localparam logic [CODE_W-1:0] FN_MOVE = 8'h86;
  localparam logic [CODE_W-1:0] FN_ADVISORY = 8'h87;
  localparam logic [CODE_W-1:0] FN_SYSTEM_OCCUPIED = 8'h88;
  localparam logic [CODE_W-1:0] FN_IN_POS = 8'h8a;
  localparam logic [CODE_W-1:0] FN_TORQUE_LIMIT = 8'h8c;
  localparam logic [CODE_W-1:0] FN_HOME_END = 8'h90;
  localparam logic [CODE_W-1:0] FN_ENCODER_ZERO = 8'h9b;
  localparam logic [CODE_W-1:0] FN_ZONE_FIRST = 8'ha0;
  localparam logic [CODE_W-1:0] FN_ZONE_SECOND = 8'ha1;
  localparam logic [CODE_W-1:0] FN_ZONE_THIRD = 8'ha2;
  localparam logic [CODE_W-1:0] FN_DIRECT_CMD_READY = 8'hcc;
  // Bit positions of the motion core status vector
  localparam int CS_W = 13;
  localparam int CS_FWD_LIM = 0;
  localparam int CS_REV_LIM = 1;
  localparam int CS_ENC_ZERO = 2;
  localparam int CS_HOME_END = 3;
  localparam int CS_DIRECT_COMMAND_READY = 4;
  localparam int CS_ADVISORY = 5;
  localparam int CS_FAULT = 6;
  localparam int CS_SYS_OCC = 7;
  localparam int CS_ZONE0 = 8;
  localparam int CS_ZONE1 = 9;
  localparam int CS_ZONE2 = 10;
  localparam int CS_IN_POS = 11;
  localparam int CS_TORQUE = 12;
  // Direct connector inputs
  localparam int PIN_W = 4;
  localparam int PIN_DEEXCITE = 0;
  localparam int PIN_FLUSH = 1;
  localparam int PIN_STOP = 2;
  localparam int PIN_PERMIT = 3;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  localparam logic [SLOTS-1:0][CODE_W-1:0] OUT_CODE_RESET = {
    8'h8c, 8'h8a, 8'h86, 8'h00, 8'ha2, 8'ha1, 8'ha0, 8'h88,
    8'h81, 8'h87, 8'hcc, 8'h90, 8'h00, 8'h9b, 8'h1d, 8'h1c};
endpackage : remote_io_pkg

// *** rtl/fcode_table.sv ***
// Function code table for the sixteen remote inputs and outputs
`timescale 1ns/1ps
module fcode_table
  import remote_io_pkg::*;
(
  input wire logic aclk,
  input wire logic aresetn,
  fcode_if.table_side tbl
);
  logic [2*SLOTS-1:0][CODE_W-1:0] mem;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      for (int i = 0; i < SLOTS; i++) begin
        mem[i] <= FN_NONE;
        mem[SLOTS+i] <= OUT_CODE_RESET[i];
      end
    end else if (tbl.wr_en) begin
      mem[tbl.wr_idx] <= tbl.wr_data;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      tbl.rd_data <= FN_NONE;
    end else begin
      tbl.rd_data <= mem[tbl.rd_idx];
    end
  end

  // The mapping logic needs every code at once, so the table is flops
  assign tbl.in_codes = mem[SLOTS-1:0];
  assign tbl.out_codes = mem[2*SLOTS-1:SLOTS];
endmodule : fcode_table

// *** rtl/remote_io_map_stop_control.sv ***
// Remote I/O function mapping with de-excitation, deviation flush and stop control
//
// Chosen here: the AXI4-Lite register port and the address map.
`timescale 1ns/1ps
// Functional notes
// - Sixteen remote input slots, each routed by its own code, reset to unassigned.
// - Except panel permit on connector and remote, a function assigned to several sources is active when any source is active.
// - An unassigned panel permit reads permanently on.
// - Permit assigned on connector and remote is on only when both are on.
// - Sixteen remote output slots, each carrying the signal its code selects.
// - Output codes reset to 28,29,155,0,144,204,135,129,136,160,161,162,0,134,138,140.
// - De-excite on while excited cuts current, drops excitation and ready.
// - De-excite off re-excites the motor, then ready is raised.
// - When not excited, brake releases with de-excite on, holds with it off.
// - In-position is never raised because a stop input is on.
// - Flush on clears deviation, syncs command to feedback, halts, discards travel.
// - After a flush stop, ready returns when flush goes off.
// - Stop on halts by the set method; travel discarded as an immediate stop starts, or once a decelerating stop reaches standstill.
// - Stop method: 0 immediate, 3 decelerating, reset value 3.
// - Immediate stop holds at latched command position; ready returns on stop off.
// - Decelerating stop runs to standstill regardless; ready only once stopped.
module remote_io_map_stop_control
  import remote_io_pkg::*;
(
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [ADDR_W-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [ADDR_W-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic [SLOTS-1:0] remote_in,
  output logic [SLOTS-1:0] remote_out,
  input wire logic [PIN_W-1:0] direct_pin,
  input wire logic direct_permit_assigned,
  input wire logic [CS_W-1:0] core_status,
  input wire logic motor_moving,
  input wire logic [POS_W-1:0] command_pos,
  input wire logic [POS_W-1:0] feedback_pos,
  output logic motor_excite,
  output logic brake_release,
  output logic ready,
  output logic in_position,
  output logic operator_panel_permit,
  output logic halt_immediate,
  output logic halt_decel,
  output logic [POS_W-1:0] hold_position,
  output logic deviation_clear,
  output logic command_follow_feedback,
  output logic travel_discard
);
  typedef enum logic [1:0] {ST_RUN, ST_IMM, ST_DEC, ST_WAIT_OFF} stop_e;

  fcode_if tbl ();

  fcode_table u_table (
    .aclk(aclk),
    .aresetn(aresetn),
    .tbl(tbl.table_side)
  );

  // Code 0 never matches a real function, so an unassigned slot drops out
  function automatic logic fn_any(input logic [SLOTS-1:0][CODE_W-1:0] codes,
                                  input logic [SLOTS-1:0] bits,
                                  input logic [CODE_W-1:0] fn);
    logic hit;
    hit = 1'b0;
    for (int i = 0; i < SLOTS; i++) begin
      hit = hit | ((codes[i] == fn) & bits[i]);
    end
    return hit;
  endfunction : fn_any

  function automatic logic fn_used(input logic [SLOTS-1:0][CODE_W-1:0] codes,
                                   input logic [CODE_W-1:0] fn);
    logic hit;
    hit = 1'b0;
    for (int i = 0; i < SLOTS; i++) begin
      hit = hit | (codes[i] == fn);
    end
    return hit;
  endfunction : fn_used

  function automatic logic out_sel(input logic [CODE_W-1:0] code,
                                   input logic [CS_W-1:0] cs,
                                   input logic rdy,
                                   input logic inpos,
                                   input logic moving);
    case (code)
      FN_FORWARD_LIMIT_ECHO: out_sel = cs[CS_FWD_LIM];
      FN_REVERSE_LIMIT_ECHO: out_sel = cs[CS_REV_LIM];
      FN_ENCODER_ZERO: out_sel = cs[CS_ENC_ZERO];
      FN_HOME_END: out_sel = cs[CS_HOME_END];
      FN_DIRECT_CMD_READY: out_sel = cs[CS_DIRECT_COMMAND_READY];
      FN_ADVISORY: out_sel = cs[CS_ADVISORY];
      FN_FAULT_NO: out_sel = cs[CS_FAULT];
      FN_SYSTEM_OCCUPIED: out_sel = cs[CS_SYS_OCC];
      FN_ZONE_FIRST: out_sel = cs[CS_ZONE0];
      FN_ZONE_SECOND: out_sel = cs[CS_ZONE1];
      FN_ZONE_THIRD: out_sel = cs[CS_ZONE2];
      FN_IN_POS: out_sel = inpos;
      FN_TORQUE_LIMIT: out_sel = cs[CS_TORQUE];
      FN_READY: out_sel = rdy;
      FN_MOVE: out_sel = moving;
      default: out_sel = 1'b0;
    endcase
  endfunction : out_sel

  // Connector pins: three stages, a change counts once stages two and three agree
  logic [PIN_W-1:0] pin_s1;
  logic [PIN_W-1:0] pin_s2;
  logic [PIN_W-1:0] pin_s3;
  logic [PIN_W-1:0] pin_q;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      pin_s1 <= '0;
      pin_s2 <= '0;
      pin_s3 <= '0;
      pin_q <= '0;
    end else begin
      pin_s1 <= direct_pin;
      pin_s2 <= pin_s1;
      pin_s3 <= pin_s2;
      for (int i = 0; i < PIN_W; i++) begin
        if (pin_s2[i] == pin_s3[i]) begin
          pin_q[i] <= pin_s3[i];
        end
      end
    end
  end

  // Combined input functions
  logic deexcite;
  logic flush;
  logic stop_in;
  logic permit_remote_used;
  logic permit_remote;
  logic next_permit;

  assign deexcite = fn_any(tbl.in_codes, remote_in, FN_DEEXCITE) | pin_q[PIN_DEEXCITE];
  assign flush = fn_any(tbl.in_codes, remote_in, FN_DEVIATION_FLUSH) | pin_q[PIN_FLUSH];
  assign stop_in = fn_any(tbl.in_codes, remote_in, FN_STOP) | pin_q[PIN_STOP];
  assign permit_remote_used = fn_used(tbl.in_codes, FN_OPERATOR_PANEL_PERMIT);
  assign permit_remote = fn_any(tbl.in_codes, remote_in, FN_OPERATOR_PANEL_PERMIT);

  always_comb begin
    unique case ({direct_permit_assigned, permit_remote_used})
      2'b00: next_permit = 1'b1;
      2'b01: next_permit = permit_remote;
      2'b10: next_permit = pin_q[PIN_PERMIT];
      2'b11: next_permit = permit_remote & pin_q[PIN_PERMIT];
    endcase
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      operator_panel_permit <= 1'b1;
    end else begin
      operator_panel_permit <= next_permit;
    end
  end

  logic flush_d;
  logic stop_d;
  logic flush_rise;
  logic stop_rise;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      flush_d <= 1'b0;
      stop_d <= 1'b0;
    end else begin
      flush_d <= flush;
      stop_d <= stop_in;
    end
  end

  assign flush_rise = flush & ~flush_d;
  assign stop_rise = stop_in & ~stop_d;

  // Excitation and brake
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      motor_excite <= 1'b1;
      brake_release <= 1'b1;
    end else begin
      motor_excite <= ~deexcite;
      // An excited motor holds itself; the brake only holds a free shaft
      brake_release <= ~deexcite ? 1'b0 : 1'b1;
      if (~deexcite & ~motor_excite) begin
        brake_release <= 1'b0;
      end else if (motor_excite) begin
        brake_release <= 1'b1;
      end
    end
  end

  // Stop sequencing
  logic [1:0] stop_method;
  stop_e state;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      state <= ST_RUN;
    end else begin
      unique case (state)
        ST_RUN: begin
          if (stop_rise) begin
            state <= (stop_method == STOP_IMMEDIATE) ? ST_IMM : ST_DEC;
          end
        end
        ST_IMM: begin
          if (!stop_in) begin
            state <= ST_RUN;
          end
        end
        ST_DEC: begin
          // Stop going off early does not cut the deceleration short
          if (!motor_moving) begin
            state <= stop_in ? ST_WAIT_OFF : ST_RUN;
          end
        end
        ST_WAIT_OFF: begin
          if (!stop_in) begin
            state <= ST_RUN;
          end
        end
      endcase
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      hold_position <= '0;
    end else if (flush_rise) begin
      hold_position <= feedback_pos;
    end else if (state == ST_RUN && stop_rise && stop_method == STOP_IMMEDIATE) begin
      hold_position <= command_pos;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      halt_immediate <= 1'b0;
      halt_decel <= 1'b0;
      deviation_clear <= 1'b0;
      command_follow_feedback <= 1'b0;
      travel_discard <= 1'b0;
    end else begin
      halt_immediate <= flush | (state == ST_IMM);
      halt_decel <= (state == ST_DEC);
      deviation_clear <= flush_rise;
      command_follow_feedback <= flush_rise;
      travel_discard <= flush_rise
                        | (state == ST_RUN && stop_rise && stop_method == STOP_IMMEDIATE)
                        | (state == ST_DEC && !motor_moving);
    end
  end

  // Ready follows excitation by a cycle, so it rises after re-excitation
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ready <= 1'b0;
    end else begin
      ready <= motor_excite & ~deexcite & ~flush & (state == ST_RUN) & ~stop_rise;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      in_position <= 1'b0;
    end else begin
      in_position <= core_status[CS_IN_POS] & ~flush & ~stop_in & (state == ST_RUN);
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      remote_out <= '0;
    end else begin
      for (int i = 0; i < SLOTS; i++) begin
        remote_out[i] <= out_sel(tbl.out_codes[i], core_status, ready, in_position,
                                 motor_moving);
      end
    end
  end

  // AXI4-Lite write path: address and data taken in either order
  logic aw_held;
  logic w_held;
  logic [ADDR_W-1:0] aw_addr;
  logic [31:0] w_data;
  logic [3:0] w_strb;
  logic do_write;
  logic wr_tbl;
  logic wr_stop;

  assign s_axi_awready = ~aw_held & ~s_axi_bvalid;
  assign s_axi_wready = ~w_held & ~s_axi_bvalid;
  assign do_write = aw_held & w_held & ~s_axi_bvalid;
  assign wr_tbl = aw_addr < TBL_SPAN && aw_addr[1:0] == 2'h0;
  assign wr_stop = aw_addr == STOP_METHOD_ADDR;
  assign tbl.wr_en = do_write & wr_tbl & w_strb[0];
  assign tbl.wr_idx = aw_addr[TBL_W+1:2];
  assign tbl.wr_data = w_data[CODE_W-1:0];

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_held <= 1'b0;
      w_held <= 1'b0;
      aw_addr <= '0;
      w_data <= '0;
      w_strb <= '0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= RESP_OKAY;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_held <= 1'b1;
        aw_addr <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_held <= 1'b1;
        w_data <= s_axi_wdata;
        w_strb <= s_axi_wstrb;
      end
      if (do_write) begin
        aw_held <= 1'b0;
        w_held <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= (wr_tbl || wr_stop || aw_addr == STATUS_ADDR) ? RESP_OKAY : RESP_SLVERR;
      end else if (s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  // Only the two documented encodings are kept; other values leave it as is
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      stop_method <= STOP_DECEL;
    end else if (do_write && wr_stop && w_strb[0]) begin
      if (w_data[1:0] == STOP_IMMEDIATE || w_data[1:0] == STOP_DECEL) begin
        stop_method <= w_data[1:0];
      end
    end
  end

  // AXI4-Lite read path: table read is registered, so answer after two edges
  logic rd_pend;
  logic [ADDR_W-1:0] ar_addr;

  assign s_axi_arready = ~rd_pend & ~s_axi_rvalid;
  assign tbl.rd_idx = s_axi_araddr[TBL_W+1:2];

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rd_pend <= 1'b0;
      ar_addr <= '0;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= '0;
      s_axi_rresp <= RESP_OKAY;
    end else begin
      if (s_axi_arvalid && s_axi_arready) begin
        rd_pend <= 1'b1;
        ar_addr <= s_axi_araddr;
      end
      if (rd_pend) begin
        rd_pend <= 1'b0;
        s_axi_rvalid <= 1'b1;
        s_axi_rresp <= RESP_OKAY;
        s_axi_rdata <= '0;
        if (ar_addr < TBL_SPAN && ar_addr[1:0] == 2'h0) begin
          s_axi_rdata[CODE_W-1:0] <= tbl.rd_data;
        end else if (ar_addr == STOP_METHOD_ADDR) begin
          s_axi_rdata[1:0] <= stop_method;
        end else if (ar_addr == STATUS_ADDR) begin
          s_axi_rdata[7:0] <= {state, operator_panel_permit, in_position,
                               stop_in, flush, motor_excite, ready};
        end else begin
          s_axi_rresp <= RESP_SLVERR;
        end
      end else if (s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
      end
    end
  end
endmodule : remote_io_map_stop_control

// *** verif/bus_master_model.sv ***
// Field bus master model exchanging the remote process image
`timescale 1ns/1ps
module bus_master_model
  import remote_io_pkg::*;
(
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [SLOTS-1:0] image_cmd,
  input wire logic [SLOTS-1:0] remote_out,
  output logic [SLOTS-1:0] remote_in,
  output logic [SLOTS-1:0] image_seen
);
  // One exchange per cycle; a master out of operation sends an all-off image
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      remote_in <= '0;
      image_seen <= '0;
    end else begin
      remote_in <= image_cmd;
      image_seen <= remote_out;
    end
  end
endmodule : bus_master_model

// *** verif/remote_io_props.sv ***
// Concurrent checks on the remote I/O mapping block ports
`timescale 1ns/1ps
module remote_io_props
  import remote_io_pkg::*;
(
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic s_axi_awready,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic s_axi_rvalid,
  input wire logic motor_moving,
  input wire logic motor_excite,
  input wire logic ready,
  input wire logic in_position,
  input wire logic halt_immediate,
  input wire logic halt_decel,
  input wire logic deviation_clear,
  input wire logic command_follow_feedback,
  input wire logic travel_discard
);
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  sequence ar_taken;
    s_axi_arvalid && s_axi_arready;
  endsequence
  sequence decel_done;
    halt_decel ##1 !halt_decel;
  endsequence
  a_read_answer: assert property (ar_taken |-> ##2 s_axi_rvalid)
    else $error("read answer not on time");
  a_read_refused: assert property (s_axi_rvalid |-> !s_axi_arready)
    else $error("read taken while answer pending");
  a_write_refused: assert property (s_axi_bvalid |-> !s_axi_awready)
    else $error("write taken while response pending");
  a_flush_once: assert property (deviation_clear |=> !deviation_clear)
    else $error("deviation clear longer than one cycle");
  a_flush_trio: assert property (deviation_clear |-> command_follow_feedback && travel_discard)
    else $error("flush pulses not together");
  // Sustained stop only, so a one-cycle lag of the registered flag is tolerated
  a_stop_no_inpos: assert property ((halt_immediate || halt_decel) && $past(halt_immediate || halt_decel) |-> !in_position)
    else $error("in position during stop");
  a_decel_holds: assert property (halt_decel && motor_moving |=> halt_decel)
    else $error("decel released while moving");
  a_decel_end: assert property (decel_done |-> $past(travel_discard))
    else $error("travel not discarded at standstill");
  a_decel_no_ready: assert property (halt_decel |-> !ready)
    else $error("ready during decel");
  a_free_no_ready: assert property (!motor_excite && $past(!motor_excite) |-> !ready)
    else $error("ready while not excited");
endmodule : remote_io_props
bind remote_io_map_stop_control remote_io_props u_props (.aclk, .aresetn, .s_axi_awready,
  .s_axi_bvalid, .s_axi_arvalid, .s_axi_arready, .s_axi_rvalid, .motor_moving, .motor_excite,
  .ready, .in_position, .halt_immediate, .halt_decel, .deviation_clear, .command_follow_feedback,
  .travel_discard);

// *** verif/testbench.sv ***
// Self-checking bench for the remote I/O mapping and stop control block
`timescale 1ns/1ps
module testbench;
  import remote_io_pkg::*;
  logic aclk = 0, aresetn = 0, s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0;
  logic s_axi_arvalid = 0, s_axi_rready = 0, direct_permit_assigned = 0, motor_moving = 0;
  logic [ADDR_W-1:0] s_axi_awaddr = '0, s_axi_araddr = '0;
  logic [31:0] s_axi_wdata = '0, s_axi_rdata;
  logic [3:0] s_axi_wstrb = 4'hf;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  logic [SLOTS-1:0] image_cmd = '0, remote_in, remote_out, image_seen;
  logic [PIN_W-1:0] direct_pin = '0;
  logic [CS_W-1:0] core_status = '0;
  logic [POS_W-1:0] command_pos = '0, feedback_pos = '0, hold_position;
  logic motor_excite, brake_release, ready, in_position, operator_panel_permit;
  logic halt_immediate, halt_decel, deviation_clear, command_follow_feedback, travel_discard;
  int error_cnt = 0, samples_checked = 0, cycles = 0, n_dc = 0, n_cf = 0, n_td = 0, k;
  remote_io_map_stop_control DUT (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid,
    .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
    .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
    .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .remote_in, .remote_out, .direct_pin,
    .direct_permit_assigned, .core_status, .motor_moving, .command_pos, .feedback_pos,
    .motor_excite, .brake_release, .ready, .in_position, .operator_panel_permit, .halt_immediate,
    .halt_decel, .hold_position, .deviation_clear, .command_follow_feedback, .travel_discard);
  bus_master_model master (.aclk, .aresetn, .image_cmd, .remote_out, .remote_in, .image_seen);
  always #12.5 aclk = ~aclk;
  // Pulses last one cycle, so they are tallied at every edge rather than polled
  always @(posedge aclk) begin
    if (deviation_clear === 1'b1) n_dc++;
    if (command_follow_feedback === 1'b1) n_cf++;
    if (travel_discard === 1'b1) n_td++;
    cycles++;
    if (cycles == 20000) begin
      error_cnt++;
      print_verdict();
    end
  end
  task print_verdict();
    if (error_cnt == 0 && samples_checked > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask : print_verdict
  task chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
    samples_checked++;
    if (got !== exp) begin
      error_cnt++;
      $display("MISMATCH %s expected %h seen %h", nm, exp, got);
    end
  endtask : chk
  task cyc(input int n);
    repeat (n) @(posedge aclk);
  endtask : cyc
  // Handshakes are judged at the falling edge, where nothing is changing
  task axi_wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er = RESP_OKAY);
    logic ta, tw, tb;
    logic [1:0] r;
    tb = 0;
    r = 2'h1;
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1;
    s_axi_wvalid <= 1;
    s_axi_bready <= 1;
    for (int n = 0; n < 50 && !tb; n++) begin
      @(negedge aclk);
      ta = s_axi_awvalid && s_axi_awready;
      tw = s_axi_wvalid && s_axi_wready;
      tb = s_axi_bvalid && s_axi_bready;
      if (tb) r = s_axi_bresp;
      @(posedge aclk);
      if (ta) s_axi_awvalid <= 0;
      if (tw) s_axi_wvalid <= 0;
    end
    s_axi_bready <= 0;
    @(posedge aclk);
    chk("bresp", 32'(er), 32'(r));
  endtask : axi_wr
  task axi_rd(input logic [7:0] a, input logic [31:0] ed, input logic [1:0] er = RESP_OKAY);
    logic ta, tr;
    logic [1:0] r;
    logic [31:0] dat;
    tr = 0;
    r = 2'h1;
    dat = '0;
    s_axi_araddr <= a;
    s_axi_arvalid <= 1;
    s_axi_rready <= 1;
    for (int n = 0; n < 50 && !tr; n++) begin
      @(negedge aclk);
      ta = s_axi_arvalid && s_axi_arready;
      tr = s_axi_rvalid && s_axi_rready;
      if (tr) r = s_axi_rresp;
      if (tr) dat = s_axi_rdata;
      @(posedge aclk);
      if (ta) s_axi_arvalid <= 0;
    end
    s_axi_rready <= 0;
    @(posedge aclk);
    chk("rresp", 32'(er), 32'(r));
    chk("rdata", ed, dat);
  endtask : axi_rd
  task t_reset_regs();
    for (int i = 0; i < SLOTS; i++) begin
      axi_rd(IN_CODE_BASE + 8'(4 * i), 32'h0);
      axi_rd(OUT_CODE_BASE + 8'(4 * i), 32'(OUT_CODE_RESET[i]));
    end
    axi_rd(STOP_METHOD_ADDR, 32'h3);
    axi_rd(STATUS_ADDR, 32'h23);
    axi_rd(8'h88, 32'h0, RESP_SLVERR);
    axi_wr(8'h88, 32'h5, RESP_SLVERR);
  endtask : t_reset_regs
  task t_idle_inputs();
    image_cmd <= 16'hffff;
    cyc(8);
    chk("halts", 32'h0, 32'({halt_immediate, halt_decel}));
    chk("ready", 32'h1, 32'(ready));
    chk("permit", 32'h1, 32'(operator_panel_permit));
    image_cmd <= '0;
  endtask : t_idle_inputs
  task t_out_map();
    core_status <= 13'h17ff;
    cyc(6);
    chk("image_seen", 32'h8ff7, 32'(image_seen));
    axi_wr(OUT_CODE_BASE, 32'(FN_NONE));
    axi_wr(OUT_CODE_BASE + 8'h0c, 32'(FN_READY));
    cyc(6);
    chk("image_seen", 32'h8ffe, 32'(image_seen));
  endtask : t_out_map
  task t_stop_decel();
    axi_wr(IN_CODE_BASE + 8'h14, 32'(FN_STOP));
    axi_wr(IN_CODE_BASE + 8'h08, 32'(FN_STOP));
    core_status <= 13'h0800;
    motor_moving <= 1;
    cyc(4);
    chk("in_position", 32'h1, 32'(in_position));
    chk("image_seen", 32'h6008, 32'(image_seen));
    k = n_td;
    image_cmd <= 16'h0020;
    cyc(6);
    chk("halt_decel", 32'h1, 32'(halt_decel));
    chk("ready", 32'h0, 32'(ready));
    chk("in_position", 32'h0, 32'(in_position));
    image_cmd <= '0;
    cyc(6);
    chk("halt_decel", 32'h1, 32'(halt_decel));
    motor_moving <= 0;
    cyc(6);
    chk("halt_decel", 32'h0, 32'(halt_decel));
    chk("discards", 32'h1, 32'(n_td - k));
    chk("ready", 32'h1, 32'(ready));
  endtask : t_stop_decel
  task t_stop_imm();
    axi_wr(STOP_METHOD_ADDR, 32'h1);
    axi_rd(STOP_METHOD_ADDR, 32'h3);
    axi_wr(STOP_METHOD_ADDR, 32'(STOP_IMMEDIATE));
    axi_rd(STOP_METHOD_ADDR, 32'h0);
    command_pos <= 32'h0000_1234;
    motor_moving <= 1;
    cyc(2);
    k = n_td;
    image_cmd <= 16'h0004;
    cyc(6);
    command_pos <= 32'h0000_9999;
    cyc(3);
    chk("halt_immediate", 32'h1, 32'(halt_immediate));
    chk("hold_position", 32'h0000_1234, hold_position);
    chk("discards", 32'h1, 32'(n_td - k));
    chk("in_position", 32'h0, 32'(in_position));
    motor_moving <= 0;
    image_cmd <= '0;
    cyc(6);
    chk("halt_immediate", 32'h0, 32'(halt_immediate));
    chk("ready", 32'h1, 32'(ready));
    axi_wr(STOP_METHOD_ADDR, 32'(STOP_DECEL));
  endtask : t_stop_imm
  task t_flush();
    axi_wr(IN_CODE_BASE + 8'h18, 32'(FN_DEVIATION_FLUSH));
    feedback_pos <= 32'h0000_5678;
    k = n_td + n_dc + n_cf;
    image_cmd <= 16'h0040;
    cyc(6);
    chk("flush pulses", 32'h3, 32'(n_td + n_dc + n_cf - k));
    chk("hold_position", 32'h0000_5678, hold_position);
    chk("ready", 32'h0, 32'(ready));
    image_cmd <= '0;
    cyc(6);
    chk("ready", 32'h1, 32'(ready));
  endtask : t_flush
  task t_deexcite();
    axi_wr(IN_CODE_BASE + 8'h1c, 32'(FN_DEEXCITE));
    image_cmd <= 16'h0080;
    cyc(6);
    chk("excite ready", 32'h0, 32'({motor_excite, ready}));
    chk("brake_release", 32'h1, 32'(brake_release));
    image_cmd <= '0;
    cyc(8);
    chk("excite ready", 32'h3, 32'({motor_excite, ready}));
  endtask : t_deexcite
  task t_permit();
    axi_wr(IN_CODE_BASE + 8'h20, 32'(FN_OPERATOR_PANEL_PERMIT));
    direct_permit_assigned <= 1;
    direct_pin <= 4'h8;
    cyc(10);
    chk("permit", 32'h0, 32'(operator_panel_permit));
    image_cmd <= 16'h0100;
    cyc(10);
    chk("permit", 32'h1, 32'(operator_panel_permit));
    direct_pin <= 4'h0;
    cyc(10);
    chk("permit", 32'h0, 32'(operator_panel_permit));
  endtask : t_permit
  initial begin
    cyc(10);
    aresetn <= 1;
    cyc(2);
    t_reset_regs();
    t_idle_inputs();
    t_out_map();
    t_stop_decel();
    t_stop_imm();
    t_flush();
    t_deexcite();
    t_permit();
    print_verdict();
  end
endmodule : testbench
